// ===== inc/crcs_pkg.sv
// Constants, register map and phase type of the reset and clock sequencer
package crcs_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLKDIV = 8'h08;

  // Control register fields and reset values
  localparam int         CTRL_MEMCLK_SEL_BIT = 0;
  localparam int         CTRL_PLL_EN_BIT     = 1;
  localparam logic       CTRL_MEMCLK_SEL_RST = 1'b0;
  localparam logic       CTRL_PLL_EN_RST     = 1'b0;

  // Status register fields
  localparam int         STAT_BOOT_LSB    = 0;
  localparam int         STAT_BOOT_MSB    = 3;
  localparam int         STAT_CLKMODE_BIT = 4;
  localparam int         STAT_PHASE_LSB   = 5;
  localparam int         STAT_PHASE_MSB   = 7;
  localparam int         STAT_BYPASS_BIT  = 8;

  // Clock channels: cpu, peripheral, memory interface, third clock output
  localparam int         NUM_CLK     = 4;
  localparam int         RATIO_W     = 4;
  localparam int         CH_CPU      = 0;
  localparam int         CH_PERIPH   = 1;
  localparam int         CH_MEM      = 2;
  localparam int         CH_CLK3     = 3;
  localparam logic [3:0] DIV_RESET   = 4'h8;
  // Run ratios, index = channel: clk3 /8, mem /2, periph /2, cpu /1
  localparam logic [NUM_CLK-1:0][RATIO_W-1:0] DIV_RUN_TAB = {4'h8, 4'h2, 4'h2, 4'h1};

  // Internal reset stretch, in reference clock cycles
  localparam int         STRETCH_CYCLES = 512;
  localparam int         STRETCH_W      = 9;
  localparam logic [STRETCH_W-1:0] STRETCH_LAST = 9'(STRETCH_CYCLES - 1);

  // Synchronised pin vector layout
  localparam int         SYNC_W       = 6;
  localparam int         SYNC_RST_BIT = 0;
  localparam int         SYNC_BOOT_LSB = 1;
  localparam int         SYNC_BOOT_MSB = 4;
  localparam int         SYNC_MODE_BIT = 5;

  // Reset phases, one-hot
  typedef enum logic [2:0] {
    PH_PIN     = 3'b001,
    PH_STRETCH = 3'b010,
    PH_RUN     = 3'b100
  } crcs_phase_type;

endpackage

// ===== verilog/crcs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module crcs_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,     // Reference clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire logic [WIDTH-1:0] d,        // Raw pin levels
  output logic      [WIDTH-1:0] q_r       // Filtered synchronous levels
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // First stage only feeds the second; change accepted when stages 2 and 3 agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          q_r[i]  <= 1'b0;
        end else begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            q_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== verilog/crcs_clk_div.sv
// Programmable divider giving a tick and a waveform that is half duty at even ratios
`timescale 1ns/1ps
`default_nettype none
module crcs_clk_div (
  input  wire logic       pclk,     // Reference clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic [3:0] ratio,    // Divide ratio, 1 to 15
  output logic            tick_r,   // One-cycle pulse per divided period
  output logic            wave_r    // Divided clock waveform
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       wave_nxt;

  // Wrap at ratio-1; a lowered ratio wraps at once instead of running long
  always_comb begin
    cnt_nxt  = (cnt_r >= 4'(ratio - 4'h1)) ? 4'h0 : 4'(cnt_r + 4'h1);
    wave_nxt = (ratio <= 4'h1) ? 1'b1 : (cnt_nxt < (ratio >> 1));
  end

  // Divider state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 4'h0;
      tick_r <= 1'b0;
      wave_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= (cnt_nxt == 4'h0);
      wave_r <= wave_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/crcs_sequencer.sv
// Device reset stretcher, boot strap latch, clock ratio and pin group sequencer
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module crcs_sequencer (
  input  wire logic        pclk,                        // Reference input clock, 200 MHz
  input  wire logic        presetn,                     // Power-on / APB reset, active low
  // Device pins
  input  wire logic        reset_pin_n,                 // External reset pin, active low
  input  wire logic [3:0]  host_data_boot_pins,         // Host data bits 14, 8, 4, 3
  input  wire logic        ref_clock_source_select,     // Reference source strap
  // APB slave
  input  wire logic        psel,                        // Slave select
  input  wire logic        penable,                     // Access phase
  input  wire logic        pwrite,                      // Write direction
  input  wire logic [7:0]  paddr,                       // Byte address
  input  wire logic [31:0] pwdata,                      // Write data
  input  wire logic [3:0]  pstrb,                       // Write byte strobes
  output logic [31:0]      prdata,                      // Read data
  output logic             pready,                      // Transfer ready
  output logic             pslverr,                     // Unmapped address
  // Sequencer outputs
  output logic             internal_reset_n,            // Stretched internal reset, active low
  output logic [3:0]       boot_config,                 // Latched boot bits {14,8,4,3}
  output logic             cpu_clock_en,                // Cpu clock tick
  output logic             peripheral_clock_en,         // Peripheral clock tick
  output logic             mem_interface_clock_en,      // Memory interface clock tick
  output logic             pll_enable,                  // 1 = PLL in path, 0 = bypassed
  output logic             mem_bus_group_oe,            // Memory bus group may drive
  output logic             bus_request_valid,           // Bus request output is valid
  output logic             pin_group1_oe,               // First peripheral group may drive
  output logic             pin_group2_oe,               // Second peripheral group may drive
  output logic             mem_clock_output,            // Memory clock output level
  output logic             mem_clock_output_oe,         // Memory clock output enable
  output logic             second_clock_output,         // Second clock output level
  output logic             second_clock_output_oe,      // Second clock output enable
  output logic             third_clock_output           // Third clock output, always driven
);

  crcs_pkg::crcs_phase_type phase_r;
  crcs_pkg::crcs_phase_type phase_nxt;

  logic [crcs_pkg::SYNC_W-1:0]    pins_s;
  logic                           pin_n_s;
  logic [crcs_pkg::STRETCH_W-1:0] stretch_cnt_r;
  logic                           clk_mode_r;
  logic                           mem_clk_sel_r;
  logic                           run_nxt;
  logic                           drive_clk_nxt;
  logic [crcs_pkg::NUM_CLK-1:0][crcs_pkg::RATIO_W-1:0] ratio;
  logic [crcs_pkg::NUM_CLK-1:0]   tick_w;
  logic [crcs_pkg::NUM_CLK-1:0]   wave_w;
  logic                           apb_setup;
  logic                           apb_write;
  logic [31:0]                    rd_data;
  logic                           rd_err;

  // Reset pin, straps and boot bits all pass the three-stage synchroniser
  crcs_pin_sync #(
    .WIDTH (crcs_pkg::SYNC_W)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({ref_clock_source_select, host_data_boot_pins, reset_pin_n}),
    .q_r     (pins_s)
  );

  assign pin_n_s = pins_s[crcs_pkg::SYNC_RST_BIT];

  // Phase sequencing: pin asserted, stretch, run
  // Pin low in any phase returns straight to PIN and restarts the sequence
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      crcs_pkg::PH_PIN: begin
        if (pin_n_s) begin
          phase_nxt = crcs_pkg::PH_STRETCH;
        end
      end
      crcs_pkg::PH_STRETCH: begin
        if (!pin_n_s) begin
          phase_nxt = crcs_pkg::PH_PIN;
        end else if (stretch_cnt_r == crcs_pkg::STRETCH_LAST) begin
          phase_nxt = crcs_pkg::PH_RUN;
        end
      end
      crcs_pkg::PH_RUN: begin
        if (!pin_n_s) begin
          phase_nxt = crcs_pkg::PH_PIN;
        end
      end
      default: begin
        phase_nxt = crcs_pkg::PH_PIN;
      end
    endcase
  end

  assign run_nxt       = (phase_nxt == crcs_pkg::PH_RUN);
  assign drive_clk_nxt = (phase_nxt != crcs_pkg::PH_PIN);

  // Phase register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= crcs_pkg::PH_PIN;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Stretch counter; same length whatever the strap, so release is always deterministic
  // Count restarts from zero if the pin drops mid-stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_cnt_r <= '0;
    end else if (phase_r == crcs_pkg::PH_STRETCH && pin_n_s) begin
      stretch_cnt_r <= 9'(stretch_cnt_r + 9'h001);
    end else begin
      stretch_cnt_r <= '0;
    end
  end

  // Internal reset follows the run phase without extra lag
  // Registered from the next phase so it rises on the very edge RUN is entered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_reset_n <= 1'b0;
    end else begin
      internal_reset_n <= run_nxt;
    end
  end

  // Straps caught on the synchronised rising edge of the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_config <= 4'h0;
      clk_mode_r  <= 1'b0;
    end else if (phase_r == crcs_pkg::PH_PIN && pin_n_s) begin
      // Board holds bits two cpu periods past the edge, well beyond sync delay
      boot_config <= pins_s[crcs_pkg::SYNC_BOOT_MSB:crcs_pkg::SYNC_BOOT_LSB];
      clk_mode_r  <= pins_s[crcs_pkg::SYNC_MODE_BIT];
    end
  end

  // Clock ratios: all /8 in reset, defaults once running
  // Ratios follow the registered phase; dividers re-wrap within one period
  always_comb begin
    for (int c = 0; c < crcs_pkg::NUM_CLK; c++) begin
      if (phase_r == crcs_pkg::PH_RUN) begin
        ratio[c] = crcs_pkg::DIV_RUN_TAB[c];
      end else begin
        ratio[c] = crcs_pkg::DIV_RESET;
      end
    end
  end

  // One divider per clock channel
  // Dividers reset on presetn only, so ticks keep going under pin reset
  genvar g;
  generate
    for (g = 0; g < crcs_pkg::NUM_CLK; g++) begin : g_div
      crcs_clk_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .ratio   (ratio[g]),
        .tick_r  (tick_w[g]),
        .wave_r  (wave_w[g])
      );
    end
  endgenerate

  assign cpu_clock_en           = tick_w[crcs_pkg::CH_CPU];
  assign peripheral_clock_en    = tick_w[crcs_pkg::CH_PERIPH];
  assign mem_interface_clock_en = tick_w[crcs_pkg::CH_MEM];

  // Pin group enables held off until the internal reset releases
  // Tri-state lands after the sync delay, not combinationally from the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_bus_group_oe  <= 1'b0;
      bus_request_valid <= 1'b0;
      pin_group1_oe     <= 1'b0;
      pin_group2_oe     <= 1'b0;
    end else begin
      mem_bus_group_oe  <= run_nxt;
      bus_request_valid <= run_nxt;
      pin_group1_oe     <= run_nxt;
      pin_group2_oe     <= run_nxt;
    end
  end

  // Clock pins come back as soon as the pin is seen high, long before 6 cpu periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_clock_output       <= 1'b0;
      mem_clock_output_oe    <= 1'b0;
      second_clock_output    <= 1'b0;
      second_clock_output_oe <= 1'b0;
      third_clock_output     <= 1'b0;
    end else begin
      mem_clock_output_oe    <= drive_clk_nxt;
      second_clock_output_oe <= drive_clk_nxt;
      if (mem_clk_sel_r) begin
        mem_clock_output <= wave_w[crcs_pkg::CH_PERIPH];
      end else begin
        mem_clock_output <= wave_w[crcs_pkg::CH_MEM];
      end
      second_clock_output <= wave_w[crcs_pkg::CH_PERIPH];
      // Third clock is driven low, never floated, during pin reset
      third_clock_output  <= drive_clk_nxt ? wave_w[crcs_pkg::CH_CLK3] : 1'b0;
    end
  end

  // APB decode; one fixed wait-free access, writes only in the run phase
  // Byte lane 0 must be strobed; other lanes carry no control bits
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite && pstrb[0]
                     && (paddr == crcs_pkg::ADDR_CTRL);

  // Control bits; device reset forces them back so the PLL starts bypassed
  // Also forced on the edge that leaves RUN, so the PLL is never in path under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_clk_sel_r <= crcs_pkg::CTRL_MEMCLK_SEL_RST;
      pll_enable    <= crcs_pkg::CTRL_PLL_EN_RST;
    end else if (phase_r != crcs_pkg::PH_RUN || !run_nxt) begin
      mem_clk_sel_r <= crcs_pkg::CTRL_MEMCLK_SEL_RST;
      pll_enable    <= crcs_pkg::CTRL_PLL_EN_RST;
    end else if (apb_write) begin
      mem_clk_sel_r <= pwdata[crcs_pkg::CTRL_MEMCLK_SEL_BIT];
      pll_enable    <= pwdata[crcs_pkg::CTRL_PLL_EN_BIT];
    end
  end

  // Read mux; unmapped addresses read zero with an error
  // Decoded from the setup-cycle address; the answer is registered on the edge that ends the setup cycle
  always_comb begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    case (paddr)
      crcs_pkg::ADDR_CTRL: begin
        rd_data[crcs_pkg::CTRL_MEMCLK_SEL_BIT] = mem_clk_sel_r;
        rd_data[crcs_pkg::CTRL_PLL_EN_BIT]     = pll_enable;
      end
      crcs_pkg::ADDR_STATUS: begin
        rd_data[crcs_pkg::STAT_BOOT_MSB:crcs_pkg::STAT_BOOT_LSB]   = boot_config;
        rd_data[crcs_pkg::STAT_CLKMODE_BIT]                        = clk_mode_r;
        rd_data[crcs_pkg::STAT_PHASE_MSB:crcs_pkg::STAT_PHASE_LSB] = phase_r;
        rd_data[crcs_pkg::STAT_BYPASS_BIT]                         = !pll_enable;
      end
      crcs_pkg::ADDR_CLKDIV: begin
        rd_data[15:0] = ratio;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // Answer registered in the setup cycle, ready in the first access cycle
  // Writes return zero read data so the bus never shows stale status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_data;
      pslverr <= rd_err;
      pready  <= 1'b1;
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== dv/crcs_sequencer_assertions.sv
// Concurrent checks on the reset and clock sequencer ports
`timescale 1ns/1ps
`default_nettype none
module crcs_sequencer_checker (
  input wire logic pclk,                    // Reference clock
  input wire logic presetn,                 // Async reset, active low
  input wire logic reset_pin_n,             // Board reset pin
  input wire logic internal_reset_n,        // Stretched reset
  input wire logic cpu_clock_en,            // Cpu tick
  input wire logic peripheral_clock_en,     // Peripheral tick
  input wire logic mem_interface_clock_en,  // Memory tick
  input wire logic pll_enable,              // PLL in path
  input wire logic mem_bus_group_oe,        // Memory bus group drive
  input wire logic bus_request_valid,       // Bus request valid
  input wire logic pin_group1_oe,           // Group one drive
  input wire logic pin_group2_oe,           // Group two drive
  input wire logic mem_clock_output_oe,     // Memory clock pin drive
  input wire logic second_clock_output_oe,  // Second clock pin drive
  input wire logic third_clock_output       // Third clock pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [9:0] stretch_cnt_r;
  logic       in_stretch;
  // Clock pins come alive at stretch entry, so they mark its start
  assign in_stretch = mem_clock_output_oe && !internal_reset_n;

  // Cycles spent in the stretch so far
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_cnt_r <= 10'h000;
    end else if (in_stretch) begin
      stretch_cnt_r <= stretch_cnt_r + 10'h001;
    end else begin
      stretch_cnt_r <= 10'h000;
    end
  end

  stretch_length_a: assert property ($rose(internal_reset_n) |-> stretch_cnt_r == 10'h200)
    else $error("internal reset stretch is not 512 cycles");
  group_release_a: assert property (pin_group1_oe == internal_reset_n && pin_group2_oe == internal_reset_n)
    else $error("peripheral groups drive while in reset");
  mem_bus_release_a: assert property (mem_bus_group_oe == internal_reset_n && bus_request_valid == internal_reset_n)
    else $error("memory bus group out of step with reset");
  clk_pins_pair_a: assert property (mem_clock_output_oe == second_clock_output_oe)
    else $error("clock pin enables disagree");
  clk3_parked_a: assert property (!second_clock_output_oe |-> !third_clock_output)
    else $error("third clock not low during pin reset");
  reset_div8_a: assert property (cpu_clock_en && in_stretch && $past(in_stretch, 8)
    |-> $past(cpu_clock_en, 8) && !$past(cpu_clock_en))
    else $error("cpu tick not at divide by 8 in reset");
  cpu_full_rate_a: assert property (internal_reset_n && $past(internal_reset_n, 8) |-> cpu_clock_en)
    else $error("cpu clock divided after reset");
  periph_half_a: assert property (internal_reset_n && $past(internal_reset_n, 8)
    |-> peripheral_clock_en != $past(peripheral_clock_en))
    else $error("peripheral clock not divide by 2");
  mem_half_a: assert property (internal_reset_n && $past(internal_reset_n, 8)
    |-> mem_interface_clock_en != $past(mem_interface_clock_en))
    else $error("memory clock not divide by 2");
  pll_bypass_a: assert property (!internal_reset_n |-> !pll_enable)
    else $error("PLL in path during reset");
  clk_out_valid_a: assert property ($rose(reset_pin_n)
    |-> ##[1:8] (mem_clock_output_oe || !reset_pin_n))
    else $error("clock pins late after reset pin release");
endmodule

bind crcs_sequencer crcs_sequencer_checker chk_u (
  .pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
  .internal_reset_n(internal_reset_n), .cpu_clock_en(cpu_clock_en),
  .peripheral_clock_en(peripheral_clock_en), .mem_interface_clock_en(mem_interface_clock_en),
  .pll_enable(pll_enable), .mem_bus_group_oe(mem_bus_group_oe),
  .bus_request_valid(bus_request_valid), .pin_group1_oe(pin_group1_oe),
  .pin_group2_oe(pin_group2_oe), .mem_clock_output_oe(mem_clock_output_oe),
  .second_clock_output_oe(second_clock_output_oe), .third_clock_output(third_clock_output)
);
`default_nettype wire

// ===== dv/crcs_board_model.sv
// Board reset source and boot strap pins
`timescale 1ns/1ps
`default_nettype none
module crcs_board_model (
  input  wire logic       pclk,         // Reference clock
  output logic            reset_pin_n,  // Reset pin, active low
  output logic [3:0]      boot_pins,    // Boot strap levels
  output logic            strap_pin     // Reference source strap
);
  localparam int HOLD_CYC = 16;  // Two cpu periods at the divide-by-8 rate

  initial begin
    reset_pin_n = 1'b0;
    boot_pins = 4'h0;
    strap_pin = 1'b1;
  end

  // Straps settle, pin rises, straps held, then flipped to their inverse levels
  task automatic release_reset(input logic [3:0] boot, input logic strap);
    @(posedge pclk);
    boot_pins <= boot;
    strap_pin <= strap;
    repeat (HOLD_CYC) @(posedge pclk);
    reset_pin_n <= 1'b1;
    repeat (HOLD_CYC) @(posedge pclk);
    boot_pins <= ~boot;
    strap_pin <= ~strap;
  endtask

  // Pin held low for a given number of cycles
  task automatic assert_reset(input int cycles);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (cycles) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== dv/crcs_sequencer_test.sv
// Self-checking bench for the reset and clock sequencer
`timescale 1ns/1ps
`default_nettype none
module crcs_sequencer_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, strap, ref_sel;
  logic        reset_pin_n, irn, cpu_en, per_en, mem_en, pll_en, bus_oe, breq_v;
  logic        grp1_oe, grp2_oe, mclk, mclk_oe, clk2, clk2_oe, clk3, p_m, p_3, p_2;
  logic [7:0]  paddr;
  logic [3:0]  pstrb, boot, boot_pins, boot_cfg;
  logic [31:0] pwdata, prdata, rd, lfsr;
  int          fail_count, checked, cycles, n, r_m, r_3, r_2, t_c, t_p, t_m;

  crcs_board_model board_u (.pclk(pclk), .reset_pin_n(reset_pin_n), .boot_pins(boot_pins),
    .strap_pin(ref_sel));
  crcs_sequencer dut_u (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
    .host_data_boot_pins(boot_pins), .ref_clock_source_select(ref_sel), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .internal_reset_n(irn),
    .boot_config(boot_cfg), .cpu_clock_en(cpu_en), .peripheral_clock_en(per_en),
    .mem_interface_clock_en(mem_en), .pll_enable(pll_en), .mem_bus_group_oe(bus_oe),
    .bus_request_valid(breq_v), .pin_group1_oe(grp1_oe), .pin_group2_oe(grp2_oe),
    .mem_clock_output(mclk), .mem_clock_output_oe(mclk_oe), .second_clock_output(clk2),
    .second_clock_output_oe(clk2_oe), .third_clock_output(clk3));

  // 200 MHz reference clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Status word as the register layout defines it
  function automatic logic [31:0] status_exp(input logic [3:0] b, input logic s,
                                             input logic [2:0] ph, input logic pll);
    status_exp = 32'h0;
    status_exp[crcs_pkg::STAT_BOOT_MSB:crcs_pkg::STAT_BOOT_LSB] = b;
    status_exp[crcs_pkg::STAT_CLKMODE_BIT] = s;
    status_exp[crcs_pkg::STAT_PHASE_MSB:crcs_pkg::STAT_PHASE_LSB] = ph;
    status_exp[crcs_pkg::STAT_BYPASS_BIT] = ~pll;
  endfunction

  // Ratios: all 8 under reset; cpu 1, periph 2, mem 2, clk3 8 after
  function automatic logic [31:0] clkdiv_exp(input logic run);
    clkdiv_exp = run ? {16'h0, 4'h8, 4'h2, 4'h2, 4'h1} : 32'h0000_8888;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("TB: checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      tally_and_finish;
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    lfsr = 32'h6FD2B8E3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int it = 0; it < 3; it++) begin
      lfsr = lfsr_next(lfsr);
      boot = (it == 0) ? 4'hF : (it == 1) ? 4'h0 : lfsr[3:0];
      strap = (it == 2) ? lfsr[4] : 1'b1;
      fork
        begin
          board_u.release_reset(boot, strap);
          check({28'h0, boot_cfg}, {28'h0, boot});
          apb(1'b0, crcs_pkg::ADDR_STATUS, 32'h0);
          check(rd, status_exp(boot, strap, 3'b010, 1'b0));
          apb(1'b0, crcs_pkg::ADDR_CLKDIV, 32'h0);
          check(rd, clkdiv_exp(1'b0));
          apb(1'b1, crcs_pkg::ADDR_CTRL, 32'h3);
        end
        begin
          n = 0;
          while (mclk_oe !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
          end
          n = 0;
          while (irn !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
          end
          check(32'(n), 32'd512);
        end
      join
      repeat (10) @(posedge pclk);
      check({28'h0, bus_oe, breq_v, grp1_oe, grp2_oe}, 32'hF);
      apb(1'b0, crcs_pkg::ADDR_CLKDIV, 32'h0);
      check(rd, clkdiv_exp(1'b1));
      pstrb <= 4'hE;
      apb(1'b1, crcs_pkg::ADDR_CTRL, 32'h3);
      pstrb <= 4'hF;
      apb(1'b0, crcs_pkg::ADDR_CTRL, 32'h0);
      check(rd, 32'h0);
      check({31'h0, pll_en}, 32'h0);
      p_m = mclk;
      p_3 = clk3;
      p_2 = clk2;
      r_2 = 0;
      r_m = 0;
      r_3 = 0;
      t_c = 0;
      t_p = 0;
      t_m = 0;
      repeat (16) begin
        @(posedge pclk);
        r_m += int'(mclk && !p_m);
        r_3 += int'(clk3 && !p_3);
        r_2 += int'(clk2 && !p_2);
        t_c += int'(cpu_en);
        t_p += int'(per_en);
        t_m += int'(mem_en);
        p_m = mclk;
        p_3 = clk3;
        p_2 = clk2;
      end
      check(32'(r_m), 32'd8);
      check(32'(r_3), 32'd2);
      check(32'(r_2), 32'd8);
      check(32'(t_c), 32'd16);
      check(32'(t_p), 32'd8);
      check(32'(t_m), 32'd8);
      apb(1'b1, crcs_pkg::ADDR_CTRL, 32'h3);
      @(posedge pclk);
      check({31'h0, pll_en}, 32'h1);
      apb(1'b0, crcs_pkg::ADDR_CTRL, 32'h0);
      check(rd, 32'h3);
      apb(1'b1, crcs_pkg::ADDR_STATUS, lfsr);
      apb(1'b0, crcs_pkg::ADDR_STATUS, 32'h0);
      check(rd, status_exp(boot, strap, 3'b100, 1'b1));
      apb(1'b0, 8'h0C, 32'h0);
      check({rd[30:0], err}, 32'h1);
      lfsr = lfsr_next(lfsr);
      board_u.assert_reset(20 + int'(lfsr[3:0]));
      check({25'h0, mclk_oe, clk2_oe, clk3, irn, pll_en, bus_oe, grp1_oe}, 32'h0);
      check({30'h0, breq_v, grp2_oe}, 32'h0);
      apb(1'b0, crcs_pkg::ADDR_CLKDIV, 32'h0);
      check(rd, clkdiv_exp(1'b0));
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
